// *** src/cbd_decoder.sv ***
// Decoder for jumps, call_segmented, returns, stack, system control, prefixes and coprocessor fields.
// Assumes the fetch unit holds instr_i and bit_val_i steady while instr_valid_i is high.
//
// Functional notes
// - Zero-extending byte move puts byte low, zeros upper eight bits, all three forms.
// - Four-byte branch-if-bit-one-and-clear branches only on one and clears the bit.
// - Branch-if-bit-zero-and-set branches only on zero and then sets the bit.
// - Push-and-call pushes the register first, then calls the absolute address.
// - Context switch pushes the register, then loads it with immediate or memory data.
// - Return-and-pop returns intra-segment, then pops the named register.
// - Software trap selects its service routine by a seven-bit trap number.
// - Inter-segment, intra-segment and interrupt returns are decoded apart.
// - Segmented jump and call carry a segment number and a code address.
// - Power-down enters power-down mode; non-maskable interrupt input assumed low.
// - Reset, break, idle, watchdog ops and end-of-init decoded; end-of-init drives pin.
// - Prefixes cover a following run whose length comes from a two-bit range.
// - Short forms: nibble 0-7 immediate, 8-B indirect, C-F indirect post-increment.
// - Top two prefix field bits pick segment/atomic, page, seg-reg/reg, page-reg.
// - Short indirect forms address only the lowest four general registers.
// - Relative conditional jump takes its condition from the opcode byte.
// - Absolute conditional jump and call: bit 8 clear predicts taken, set not taken.
// - Absolute jump bit 9 is a prefetch hint for short backward targets.
// - Bit set and clear take bit position 0 to 15 from the opcode byte.
// - Coprocessor repeat field 31:29: regular, two user repeats, others reserved.
// - Coprocessor bits 15:12 select index pointer and its update.
// - Coprocessor bits 26:24 select the general pointer update with offsets 0 and 1.
// - The undefined opcode 3B and any reserved coprocessor encoding raise a hardware trap.
`timescale 1ns/100ps
module cbd_decoder (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic instr_valid_i,
   input wire logic [31:0] instr_i,
   input wire logic bit_val_i,
   output logic ready_o,
   output logic dec_valid_o,
   output cbd_pkg::cbd_op_type op_class_o,
   output logic [7:0] reg_o,
   output logic [15:0] target_o,
   output logic [7:0] seg_o,
   output logic [3:0] cond_o,
   output logic predict_not_taken_o,
   output logic prefetch_hint_o,
   output logic branch_taken_o,
   output logic [3:0] bit_pos_o,
   output logic bit_wr_o,
   output logic bit_wr_val_o,
   output logic [1:0] move_form_o,
   output logic [1:0] operand_kind_o,
   output logic [1:0] ptr_o,
   output logic [2:0] data3_o,
   output cbd_pkg::cbd_pfx_type prefix_kind_o,
   output logic prefix_active_o,
   output logic [6:0] trap_num_o,
   output logic [1:0] repeat_o,
   output logic idx_sel_o,
   output logic [2:0] idx_op_o,
   output logic [2:0] gpr_op_o,
   output logic hw_trap_o,
   output logic reset_output_pin_o
);
   import cbd_pkg::*;

   typedef enum logic {ST_IDLE, ST_SECOND} cbd_state_type;

   cbd_state_type state_q, state_d;
   cbd_op_type cls, second_q;
   logic [2:0] pfx_left_q, pfx_left_d;
   logic ready_q;

   wire take = instr_valid_i && ready_q;
   wire [7:0] opc = instr_i[7:0];
   wire is_jump_relative_cond = opc[3:0] == NIB_JUMP_RELATIVE_COND;
   wire is_bit_clear_op = opc[3:0] == NIB_BIT_CLEAR_OP;
   wire is_bit_set_op = opc[3:0] == NIB_BIT_SET_OP;
   wire is_short = (opc[3:1] == NIB_SHORT_HI) && !opc[7];
   wire is_move_byte_zero_extend = (opc == OP_MOVE_BYTE_ZERO_EXTEND_RR) || (opc == OP_MOVE_BYTE_ZERO_EXTEND_RM) || (opc == OP_MOVE_BYTE_ZERO_EXTEND_MR);
   wire is_bitjmp = (opc == OP_JB) || (opc == OP_JBC) || (opc == OP_JNB) || (opc == OP_BRANCH_IF_BIT_ZERO_AND_SET);
   wire is_context_switch = (opc == OP_CONTEXT_SWITCH_I) || (opc == OP_CONTEXT_SWITCH_M);
   wire is_pfx = (opc == OP_PFX_SHORT) || (opc == OP_PFX_LONG);
   wire is_cop = opc == OP_COPROC;
   wire [2:0] rpt_f = instr_i[31:29];
   wire cop_bad = (rpt_f != RPT_REGULAR && rpt_f != RPT_USER_REPEAT_VARIANT_ZERO && rpt_f != RPT_USER_REPEAT_VARIANT_ONE)
      || instr_i[14:12] == PTR_RESERVED || instr_i[26:24] == PTR_RESERVED;
   wire two_step = (opc == OP_PUSH_AND_CALL) || is_context_switch || (opc == OP_RETURN_AND_POP);
   // Bit jump outcome: the "one" forms branch on a set bit, the "zero" forms on a clear bit.
   wire bit_hit = ((opc == OP_JB) || (opc == OP_JBC)) ? bit_val_i : !bit_val_i;
   wire bit_mod = (opc == OP_JBC) || (opc == OP_BRANCH_IF_BIT_ZERO_AND_SET);
   wire [1:0] pfx_sel = instr_i[15:14];
   wire pfx_short = opc == OP_PFX_SHORT;
   cbd_pfx_type pfx_k;

   // Prefix selection by the two top bits of the operand field.
   always_comb begin
      if (pfx_sel == PFX_SEL_SEG) begin
         pfx_k = pfx_short ? PFX_ATOMIC : PFX_SEG;
      end else if (pfx_sel == PFX_SEL_PAGE) begin
         pfx_k = PFX_PAGE;
      end else if (pfx_sel == PFX_SEL_SEGREG) begin
         pfx_k = pfx_short ? PFX_REG : PFX_SEG_REG;
      end else begin
         pfx_k = PFX_PAGE_REG;
      end
   end

   // Instruction class for the first micro-operation.
   always_comb begin
      if (opc == OP_UNDEF || (is_cop && cop_bad)) cls = OPC_HW_TRAP;
      else if (is_jump_relative_cond) cls = OPC_JMP_REL;
      else if (is_bit_clear_op) cls = OPC_BIT_CLR;
      else if (is_bit_set_op) cls = OPC_BIT_SET;
      else if (is_short) cls = OPC_SHORT_ARITH;
      else if (is_move_byte_zero_extend) cls = OPC_MOVE_ZX;
      else if (is_bitjmp) cls = OPC_JMP_BIT;
      else if (opc == OP_JMPA) cls = OPC_JMP_ABS;
      else if (opc == OP_JUMP_INDIRECT_COND) cls = OPC_JMP_IND;
      else if (opc == OP_JUMP_SEGMENTED) cls = OPC_JMP_SEG;
      else if (opc == OP_CALL_ABSOLUTE_COND) cls = OPC_CALL_ABS;
      else if (opc == OP_CALL_INDIRECT_COND) cls = OPC_CALL_IND;
      else if (opc == OP_CALL_RELATIVE) cls = OPC_CALL_REL;
      else if (opc == OP_CALL_SEGMENTED) cls = OPC_CALL_SEG;
      else if (opc == OP_TRAP) cls = OPC_TRAP;
      else if (opc == OP_PUSH || opc == OP_PUSH_AND_CALL || is_context_switch) cls = OPC_PUSH;
      else if (opc == OP_POP) cls = OPC_POP;
      else if (opc == OP_RET || opc == OP_RETURN_AND_POP) cls = OPC_RET_INTRA;
      else if (opc == OP_RETURN_INTER_SEGMENT) cls = OPC_RET_INTER;
      else if (opc == OP_RETURN_FROM_INTERRUPT) cls = OPC_RET_IRQ;
      else if (opc == OP_SOFTWARE_RESET_OP) cls = OPC_SW_RESET;
      else if (opc == OP_SOFTWARE_BREAK_OP) cls = OPC_SW_BREAK;
      else if (opc == OP_IDLE) cls = OPC_IDLE;
      else if (opc == OP_POWER_DOWN_OP) cls = OPC_POWER_DOWN_OP;
      else if (opc == OP_WATCHDOG_SERVICE_OP) cls = OPC_WDT_SRV;
      else if (opc == OP_WATCHDOG_DISABLE_OP) cls = OPC_WDT_DIS;
      else if (opc == OP_WATCHDOG_ENABLE_OP) cls = OPC_WDT_EN;
      else if (opc == OP_END_OF_INIT_OP) cls = OPC_END_OF_INIT_OP;
      else if (is_pfx) cls = OPC_PREFIX;
      else if (is_cop) cls = OPC_COPROC;
      else cls = OPC_OTHER;
   end

   // Two-step sequencer: the fetch side is stalled for the second micro-operation.
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (take && two_step && cls != OPC_HW_TRAP) begin
               state_d = ST_SECOND;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // Remaining length of the prefixed run; the prefix itself loads it.
   always_comb begin
      pfx_left_d = pfx_left_q;
      if (take && is_pfx) begin
         pfx_left_d = {1'b0, instr_i[13:12]} + 3'h1;
      end else if (take && pfx_left_q != 3'h0) begin
         pfx_left_d = pfx_left_q - 3'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         ready_q <= 1'b0;
         pfx_left_q <= 3'h0;
         prefix_active_o <= 1'b0;
         reset_output_pin_o <= 1'b1;
         second_q <= OPC_NONE;
      end else begin
         state_q <= state_d;
         ready_q <= state_d == ST_IDLE;
         pfx_left_q <= pfx_left_d;
         prefix_active_o <= pfx_left_d != 3'h0;
         if (take && cls == OPC_END_OF_INIT_OP) begin
            reset_output_pin_o <= 1'b0;
         end
         if (take) begin
            second_q <= (opc == OP_PUSH_AND_CALL) ? OPC_CALL_ABS : is_context_switch ? OPC_LOAD : OPC_POP;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dec_valid_o <= 1'b0;
         op_class_o <= OPC_NONE;
         hw_trap_o <= 1'b0;
         branch_taken_o <= 1'b0;
         bit_wr_o <= 1'b0;
      end else begin
         dec_valid_o <= take || state_q == ST_SECOND;
         op_class_o <= state_q == ST_SECOND ? second_q : take ? cls : OPC_NONE;
         hw_trap_o <= take && cls == OPC_HW_TRAP;
         branch_taken_o <= take && is_bitjmp && bit_hit;
         bit_wr_o <= take && is_bitjmp && bit_hit && bit_mod;
      end
   end

   // Operand fields, loaded on every accepted word.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reg_o <= 8'h00;
         target_o <= 16'h0000;
         seg_o <= 8'h00;
         cond_o <= 4'h0;
         predict_not_taken_o <= 1'b0;
         prefetch_hint_o <= 1'b0;
         bit_pos_o <= 4'h0;
         bit_wr_val_o <= 1'b0;
         move_form_o <= 2'h0;
         operand_kind_o <= 2'h0;
         ptr_o <= 2'h0;
         data3_o <= 3'h0;
         prefix_kind_o <= PFX_NONE;
         trap_num_o <= 7'h00;
         repeat_o <= 2'h0;
         idx_sel_o <= 1'b0;
         idx_op_o <= 3'h0;
         gpr_op_o <= 3'h0;
      end else if (take) begin
         reg_o <= instr_i[15:8];
         target_o <= instr_i[31:16];
         seg_o <= instr_i[15:8];
         cond_o <= is_jump_relative_cond ? opc[7:4] : instr_i[15:12];
         predict_not_taken_o <= instr_i[PRED_BIT];
         prefetch_hint_o <= (opc == OP_JMPA) && instr_i[HINT_BIT];
         bit_pos_o <= (is_bit_clear_op || is_bit_set_op) ? opc[7:4] : instr_i[31:28];
         bit_wr_val_o <= opc == OP_BRANCH_IF_BIT_ZERO_AND_SET;
         move_form_o <= !is_move_byte_zero_extend ? 2'h0 : (opc == OP_MOVE_BYTE_ZERO_EXTEND_RR) ? FORM_REG
            : (opc == OP_MOVE_BYTE_ZERO_EXTEND_RM) ? FORM_MEM_TO_REG : FORM_REG_TO_MEM;
         operand_kind_o <= !is_short ? 2'h0 : !instr_i[11] ? KIND_IMM
            : instr_i[10] ? KIND_IND_INC : KIND_IND;
         ptr_o <= instr_i[9:8];
         data3_o <= instr_i[10:8];
         prefix_kind_o <= is_pfx ? pfx_k : PFX_NONE;
         trap_num_o <= instr_i[14:8];
         repeat_o <= rpt_f[1:0];
         idx_sel_o <= instr_i[15];
         idx_op_o <= instr_i[14:12];
         gpr_op_o <= instr_i[26:24];
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   AST_ZX_FORM: assert property (take && opc == OP_MOVE_BYTE_ZERO_EXTEND_RM |=>
      op_class_o == OPC_MOVE_ZX && move_form_o == FORM_MEM_TO_REG)
      else $error("zero-extend form wrong");
   AST_JBC: assert property (take && opc == OP_JBC && bit_val_i |=>
      branch_taken_o && bit_wr_o && !bit_wr_val_o) else $error("bit-one-clear wrong");
   AST_BRANCH_IF_BIT_ZERO_AND_SET: assert property (take && opc == OP_BRANCH_IF_BIT_ZERO_AND_SET |=>
      branch_taken_o == !$past(bit_val_i) && bit_wr_o == branch_taken_o && bit_wr_val_o)
      else $error("bit-zero-set wrong");
   AST_PUSH_AND_CALL: assert property (take && opc == OP_PUSH_AND_CALL |=>
      op_class_o == OPC_PUSH && !ready_o ##1 op_class_o == OPC_CALL_ABS)
      else $error("push-and-call order wrong");
   AST_CONTEXT_SWITCH: assert property (take && is_context_switch |=>
      op_class_o == OPC_PUSH ##1 op_class_o == OPC_LOAD && dec_valid_o)
      else $error("context switch order wrong");
   AST_RETURN_AND_POP: assert property (take && opc == OP_RETURN_AND_POP |=>
      op_class_o == OPC_RET_INTRA ##1 op_class_o == OPC_POP) else $error("return-pop wrong");
   AST_TRAP: assert property (take && opc == OP_TRAP |=>
      trap_num_o == $past(instr_i[14:8])) else $error("trap number wrong");
   AST_END_OF_INIT_OP: assert property (take && opc == OP_END_OF_INIT_OP |=>
      !reset_output_pin_o [*2]) else $error("end-of-init pin not low");
   AST_PFX: assert property (take && is_pfx && instr_i[13:12] == 2'h0 |=>
      prefix_active_o && pfx_left_q == 3'h1)
      else $error("prefix run length wrong");
   AST_PFX_END: assert property (take && !is_pfx && pfx_left_q == 3'h1 |=>
      !prefix_active_o)
      else $error("prefix run not closed");
   AST_HINT: assert property (take && opc != OP_JMPA |=>
      !prefetch_hint_o)
      else $error("prefetch hint on wrong class");
   AST_PRED: assert property (take |=>
      predict_not_taken_o == $past(instr_i[PRED_BIT]))
      else $error("prediction bit wrong");
   AST_BITPOS: assert property (take && is_bit_set_op |=>
      op_class_o == OPC_BIT_SET && bit_pos_o == $past(opc[7:4]))
      else $error("bit position wrong");
   AST_SHORT: assert property (take && is_short && instr_i[11:10] == 2'h3 |=>
      operand_kind_o == KIND_IND_INC && ptr_o == $past(instr_i[9:8]))
      else $error("short form operand wrong");
   AST_COP_RPT: assert property (take && is_cop && rpt_f[2] |=>
      hw_trap_o && op_class_o == OPC_HW_TRAP)
      else $error("reserved repeat not trapped");
   AST_SEG: assert property (take && opc == OP_JUMP_SEGMENTED |=>
      seg_o == $past(instr_i[15:8]) && target_o == $past(instr_i[31:16]))
      else $error("segment jump fields wrong");
   AST_IDX: assert property (take && is_cop && !cop_bad |=>
      idx_sel_o == $past(instr_i[15]) && idx_op_o == $past(instr_i[14:12]))
      else $error("index pointer field wrong");
   AST_JUMP_RELATIVE_COND: assert property (take && is_jump_relative_cond |=>
      cond_o == $past(opc[7:4])) else $error("relative condition wrong");
   AST_UNDEF: assert property (take && opc == OP_UNDEF |=>
      hw_trap_o && op_class_o == OPC_HW_TRAP && ready_o) else $error("undefined not trapped");

   CVR_PUSH_AND_CALL: cover property (take && opc == OP_PUSH_AND_CALL ##2 dec_valid_o);
   CVR_PFX: cover property (take && is_pfx ##1 prefix_active_o);
   CVR_TRAP: cover property (hw_trap_o);

   assign ready_o = ready_q;
endmodule

// *** src/cbd_pkg.sv ***
// Opcode values, operand field positions and encodings for the branch and system decoder.
// Assumes one 32-bit instruction word per request with the opcode byte in bits 7 to 0.
package cbd_pkg;
   localparam logic [7:0] OP_MOVE_BYTE_ZERO_EXTEND_RR = 8'hc0;
   localparam logic [7:0] OP_MOVE_BYTE_ZERO_EXTEND_RM = 8'hc2;
   localparam logic [7:0] OP_MOVE_BYTE_ZERO_EXTEND_MR = 8'hc5;
   localparam logic [7:0] OP_JMPA = 8'hea;
   localparam logic [7:0] OP_JUMP_INDIRECT_COND = 8'h9c;
   localparam logic [7:0] OP_JUMP_SEGMENTED = 8'hfa;
   localparam logic [7:0] OP_JB = 8'h8a;
   localparam logic [7:0] OP_JBC = 8'haa;
   localparam logic [7:0] OP_JNB = 8'h9a;
   localparam logic [7:0] OP_BRANCH_IF_BIT_ZERO_AND_SET = 8'hba;
   localparam logic [7:0] OP_CALL_ABSOLUTE_COND = 8'hca;
   localparam logic [7:0] OP_CALL_INDIRECT_COND = 8'hab;
   localparam logic [7:0] OP_CALL_RELATIVE = 8'hbb;
   localparam logic [7:0] OP_CALL_SEGMENTED = 8'hda;
   localparam logic [7:0] OP_PUSH_AND_CALL = 8'he2;
   localparam logic [7:0] OP_TRAP = 8'h9b;
   localparam logic [7:0] OP_PUSH = 8'he4;
   localparam logic [7:0] OP_POP = 8'hf4;
   localparam logic [7:0] OP_CONTEXT_SWITCH_I = 8'hc6;
   localparam logic [7:0] OP_CONTEXT_SWITCH_M = 8'hd6;
   localparam logic [7:0] OP_RET = 8'hcb;
   localparam logic [7:0] OP_RETURN_INTER_SEGMENT = 8'hdb;
   localparam logic [7:0] OP_RETURN_AND_POP = 8'heb;
   localparam logic [7:0] OP_RETURN_FROM_INTERRUPT = 8'hfb;
   localparam logic [7:0] OP_SOFTWARE_RESET_OP = 8'hb7;
   localparam logic [7:0] OP_SOFTWARE_BREAK_OP = 8'h8c;
   localparam logic [7:0] OP_IDLE = 8'h87;
   localparam logic [7:0] OP_POWER_DOWN_OP = 8'h97;
   localparam logic [7:0] OP_WATCHDOG_SERVICE_OP = 8'ha7;
   localparam logic [7:0] OP_WATCHDOG_DISABLE_OP = 8'ha5;
   localparam logic [7:0] OP_WATCHDOG_ENABLE_OP = 8'h85;
   localparam logic [7:0] OP_END_OF_INIT_OP = 8'hb5;
   localparam logic [7:0] OP_PFX_SHORT = 8'hd1;
   localparam logic [7:0] OP_PFX_LONG = 8'hd7;
   localparam logic [7:0] OP_COPROC = 8'h93;
   localparam logic [7:0] OP_UNDEF = 8'h3b;
   localparam logic [3:0] NIB_JUMP_RELATIVE_COND = 4'hd;
   localparam logic [3:0] NIB_BIT_CLEAR_OP = 4'he;
   localparam logic [3:0] NIB_BIT_SET_OP = 4'hf;
   localparam logic [2:0] NIB_SHORT_HI = 3'h4;
   localparam int PRED_BIT = 8;
   localparam int HINT_BIT = 9;
   localparam logic [2:0] PTR_RESERVED = 3'h0;
   localparam logic [2:0] RPT_REGULAR = 3'h0;
   localparam logic [2:0] RPT_USER_REPEAT_VARIANT_ZERO = 3'h2;
   localparam logic [2:0] RPT_USER_REPEAT_VARIANT_ONE = 3'h3;
   localparam logic [1:0] PFX_SEL_SEG = 2'h0;
   localparam logic [1:0] PFX_SEL_PAGE = 2'h1;
   localparam logic [1:0] PFX_SEL_SEGREG = 2'h2;
   localparam logic [1:0] FORM_REG = 2'h1;
   localparam logic [1:0] FORM_MEM_TO_REG = 2'h2;
   localparam logic [1:0] FORM_REG_TO_MEM = 2'h3;
   localparam logic [1:0] KIND_IMM = 2'h1;
   localparam logic [1:0] KIND_IND = 2'h2;
   localparam logic [1:0] KIND_IND_INC = 2'h3;
   typedef enum logic [5:0] {
      OPC_NONE, OPC_MOVE_ZX, OPC_JMP_ABS, OPC_JMP_IND, OPC_JMP_REL, OPC_JMP_SEG, OPC_JMP_BIT,
      OPC_CALL_ABS, OPC_CALL_IND, OPC_CALL_REL, OPC_CALL_SEG, OPC_TRAP, OPC_PUSH, OPC_POP,
      OPC_LOAD, OPC_RET_INTRA, OPC_RET_INTER, OPC_RET_IRQ, OPC_SW_RESET, OPC_SW_BREAK,
      OPC_IDLE, OPC_POWER_DOWN_OP, OPC_WDT_SRV, OPC_WDT_DIS, OPC_WDT_EN, OPC_END_OF_INIT_OP, OPC_PREFIX,
      OPC_BIT_SET, OPC_BIT_CLR, OPC_SHORT_ARITH, OPC_COPROC, OPC_HW_TRAP, OPC_OTHER
   } cbd_op_type;
   typedef enum logic [2:0] {
      PFX_NONE, PFX_ATOMIC, PFX_SEG, PFX_PAGE, PFX_REG, PFX_SEG_REG, PFX_PAGE_REG
   } cbd_pfx_type;
endpackage

// *** test/cbd_fetch_model.sv ***
// Fetch unit model that offers instruction words to the decoder.
// Assumes the caller invokes its tasks just after a rising clock edge.
`timescale 1ns/100ps
module cbd_fetch_model (
   input wire logic clk_i,
   input wire logic ready_i,
   output logic valid_o,
   output logic [31:0] word_o,
   output logic bit_o
);
   initial begin
      valid_o = 1'b0;
      word_o = 32'h0;
      bit_o = 1'b0;
   end
   // Holds the word until the decoder is seen ready at an edge.
   task automatic offer(input logic [31:0] w, input logic b);
      valid_o <= 1'b1;
      word_o <= w;
      bit_o <= b;
      do begin
         @(posedge clk_i);
      end while (ready_i !== 1'b1);
   endtask
   // Idle cycles put junk on the released lines.
   task automatic rest(input int n);
      repeat (n) begin
         valid_o <= 1'b0;
         word_o <= $urandom;
         bit_o <= ~bit_o;
         @(posedge clk_i);
      end
   endtask
endmodule

// *** test/test_cbd_decoder.sv ***
// Self-checking bench for the branch and system decoder.
// Assumes the fetch model drives the word side; results are matched from a queue.
`timescale 1ns/100ps
module test_cbd_decoder;
   import cbd_pkg::*;
   typedef struct {cbd_op_type op; int f1; logic [15:0] v1; int f2; logic [15:0] v2;} cbd_note_type;
   logic clk_i = 1'b0, rst_i = 1'b1, instr_valid_i, bit_val_i, ready_o, dec_valid_o;
   logic [31:0] instr_i, w;
   cbd_op_type op_class_o;
   cbd_pfx_type prefix_kind_o;
   logic [7:0] reg_o, seg_o;
   logic [15:0] target_o;
   logic [3:0] cond_o, bit_pos_o;
   logic [1:0] move_form_o, operand_kind_o, ptr_o, repeat_o;
   logic [2:0] data3_o, idx_op_o, gpr_op_o;
   logic [6:0] trap_num_o;
   logic predict_not_taken_o, prefetch_hint_o, branch_taken_o, bit_wr_o, bit_wr_val_o;
   logic prefix_active_o, idx_sel_o, hw_trap_o, reset_output_pin_o, tk, wr, ok;
   int err_count = 0, comparisons = 0, i, k, ir;
   cbd_note_type notes[$], n;
   logic [7:0] t_op[22] = '{8'hea, 8'hca, 8'h9c, 8'hfa, 8'hda, 8'hab, 8'hbb, 8'h9b, 8'hcb,
      8'hdb, 8'hfb, 8'he4, 8'hf4, 8'hb7, 8'h8c, 8'h87, 8'h97, 8'ha7, 8'ha5, 8'h85, 8'h3b, 8'hb5};
   cbd_op_type t_cls[22] = '{OPC_JMP_ABS, OPC_CALL_ABS, OPC_JMP_IND, OPC_JMP_SEG, OPC_CALL_SEG,
      OPC_CALL_IND, OPC_CALL_REL, OPC_TRAP, OPC_RET_INTRA, OPC_RET_INTER, OPC_RET_IRQ, OPC_PUSH,
      OPC_POP, OPC_SW_RESET, OPC_SW_BREAK, OPC_IDLE, OPC_POWER_DOWN_OP, OPC_WDT_SRV, OPC_WDT_DIS,
      OPC_WDT_EN, OPC_HW_TRAP, OPC_END_OF_INIT_OP};
   int t_fa[22] = '{5, 5, 0, 3, 3, 0, 0, 11, 0, 0, 0, 1, 1, 0, 0, 0, 0, 0, 0, 0, 13, 0};
   int t_fb[22] = '{2, 2, 0, 2, 2, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
   logic [7:0] p_op[6] = '{8'hd1, 8'hd1, 8'hd7, 8'hd7, 8'hd7, 8'hd7};
   logic [1:0] p_sel[6] = '{2'h0, 2'h2, 2'h0, 2'h1, 2'h2, 2'h3};
   cbd_pfx_type p_kind[6] = '{PFX_ATOMIC, PFX_REG, PFX_SEG, PFX_PAGE, PFX_SEG_REG, PFX_PAGE_REG};
   logic [7:0] s_op[4] = '{8'he2, 8'hc6, 8'hd6, 8'heb};
   cbd_op_type s_a[4] = '{OPC_PUSH, OPC_PUSH, OPC_PUSH, OPC_RET_INTRA};
   cbd_op_type s_b[4] = '{OPC_CALL_ABS, OPC_LOAD, OPC_LOAD, OPC_POP};
   cbd_fetch_model i_fetch (.clk_i(clk_i), .ready_i(ready_o), .valid_o(instr_valid_i),
      .word_o(instr_i), .bit_o(bit_val_i));
   cbd_decoder i_dut (.clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
      .instr_i(instr_i), .bit_val_i(bit_val_i), .ready_o(ready_o), .dec_valid_o(dec_valid_o),
      .op_class_o(op_class_o), .reg_o(reg_o), .target_o(target_o), .seg_o(seg_o),
      .cond_o(cond_o), .predict_not_taken_o(predict_not_taken_o),
      .prefetch_hint_o(prefetch_hint_o), .branch_taken_o(branch_taken_o),
      .bit_pos_o(bit_pos_o), .bit_wr_o(bit_wr_o), .bit_wr_val_o(bit_wr_val_o),
      .move_form_o(move_form_o), .operand_kind_o(operand_kind_o), .ptr_o(ptr_o),
      .data3_o(data3_o), .prefix_kind_o(prefix_kind_o), .prefix_active_o(prefix_active_o),
      .trap_num_o(trap_num_o), .repeat_o(repeat_o), .idx_sel_o(idx_sel_o),
      .idx_op_o(idx_op_o), .gpr_op_o(gpr_op_o), .hw_trap_o(hw_trap_o),
      .reset_output_pin_o(reset_output_pin_o));
   always #2.5 clk_i = ~clk_i;
   function automatic logic [15:0] view(input int f);
      case (f)
         1: view = {8'h0, reg_o};
         2: view = target_o;
         3: view = {8'h0, seg_o};
         4: view = {12'h0, cond_o};
         5: view = {14'h0, prefetch_hint_o, predict_not_taken_o};
         6: view = {13'h0, branch_taken_o, bit_wr_o, bit_wr_o & bit_wr_val_o};
         7: view = {12'h0, bit_pos_o};
         8: view = {14'h0, move_form_o};
         9: view = {9'h0, operand_kind_o, ptr_o, data3_o};
         10: view = {13'h0, prefix_kind_o};
         11: view = {9'h0, trap_num_o};
         12: view = {7'h0, repeat_o, idx_sel_o, idx_op_o, gpr_op_o};
         13: view = {15'h0, hw_trap_o};
         14: view = {15'h0, ready_o};
         default: view = {15'h0, prefix_active_o};
      endcase
   endfunction
   function automatic logic [15:0] exp_of(input int f, input logic [31:0] x);
      case (f)
         1, 3: exp_of = {8'h0, x[15:8]};
         2: exp_of = x[31:16];
         5: exp_of = {14'h0, x[9] & (x[7:0] == OP_JMPA), x[8]};
         11: exp_of = {9'h0, x[14:8]};
         default: exp_of = 16'h1;
      endcase
   endfunction
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic put(input cbd_op_type op, input int f1, input logic [15:0] v1,
      input int f2 = 0, input logic [15:0] v2 = 16'h0);
      notes.push_back('{op, f1, v1, f2, v2});
   endtask
   task automatic go(input logic [31:0] x, input logic b, input cbd_op_type op, input int f1,
      input logic [15:0] v1, input int f2 = 0, input logic [15:0] v2 = 16'h0);
      put(op, f1, v1, f2, v2);
      i_fetch.offer(x, b);
   endtask
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk_i) begin
      if (!rst_i && dec_valid_o === 1'b1) begin
         if (notes.size() == 0) chk("stray_pulse", 16'h0, 16'h1);
         else begin
            n = notes.pop_front();
            chk("op_class", 16'(n.op), 16'(op_class_o));
            if (n.f1 != 0) chk($sformatf("field%0d", n.f1), n.v1, view(n.f1));
            if (n.f2 != 0) chk($sformatf("field%0d", n.f2), n.v2, view(n.f2));
         end
      end
   end
   initial begin
      #50000;
      chk("watchdog", 16'h0, 16'h1);
      tally_and_finish();
   end
   initial begin
      void'($urandom(2));
      repeat (4) @(posedge clk_i);
      chk("pin_in_reset", 16'h1, {15'h0, reset_output_pin_o});
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (i = 0; i < 3; i++) begin
         w = {$urandom, 8'(8'hc0 + (i == 2 ? 5 : 2 * i))};
         go(w, 1'b0, OPC_MOVE_ZX, 8, 16'(i + 1));
      end
      $display("test zero_extend_move done");
      for (i = 0; i < 22; i++) begin
         w = {$urandom, t_op[i]};
         ir = $urandom % 48;
         w[9] = (t_op[i] == OP_JMPA) ? (ir > 0 && ir <= 32) : w[9];
         w[31:16] = w[31:16] - 16'(ir);
         i_fetch.rest($urandom % 3);
         go(w, 1'b0, t_cls[i], t_fa[i], exp_of(t_fa[i], w), t_fb[i], exp_of(t_fb[i], w));
      end
      i_fetch.rest(4);
      chk("pin_after_init", 16'h0, {15'h0, reset_output_pin_o});
      $display("test jump_call_system done");
      for (i = 0; i < 4; i++) begin
         w = {$urandom, s_op[i]};
         go(w, 1'b0, s_a[i], 1, exp_of(1, w), 14, 16'h0);
         put(s_b[i], (s_b[i] == OPC_CALL_ABS) ? 2 : 1, exp_of((s_b[i] == OPC_CALL_ABS) ? 2 : 1, w), 14, 16'h1);
      end
      $display("test two_step done");
      for (i = 0; i < 8; i++) begin
         w = {$urandom, 4'(i / 2 * 3 + 8), 4'ha};
         w[7:0] = (i < 2) ? OP_JB : (i < 4) ? OP_JBC : (i < 6) ? OP_JNB : OP_BRANCH_IF_BIT_ZERO_AND_SET;
         tk = (i < 4) ? i[0] : ~i[0];
         wr = tk && (w[7:0] == OP_JBC || w[7:0] == OP_BRANCH_IF_BIT_ZERO_AND_SET);
         go(w, i[0], OPC_JMP_BIT, 6, {13'h0, tk, wr, wr && w[7:0] == OP_BRANCH_IF_BIT_ZERO_AND_SET}, 7, 16'(w[31:28]));
      end
      $display("test bit_jump done");
      for (i = 0; i < 16; i++) begin
         go({$urandom, 4'(i), NIB_JUMP_RELATIVE_COND}, 1'b0, OPC_JMP_REL, 4, 16'(i));
         go({$urandom, 4'(i), NIB_BIT_CLEAR_OP}, 1'b0, OPC_BIT_CLR, 7, 16'(i));
         go({$urandom, 4'(i), NIB_BIT_SET_OP}, 1'b0, OPC_BIT_SET, 7, 16'(i));
         w = {$urandom, 1'b0, 3'($urandom), NIB_SHORT_HI, 1'($urandom)};
         w[11:8] = 4'(i);
         go(w, 1'b0, OPC_SHORT_ARITH, 9, {9'h0, (i < 8) ? KIND_IMM : (i < 12) ? KIND_IND : KIND_IND_INC, w[9:8], w[10:8]});
      end
      $display("test fields done");
      for (i = 0; i < 6; i++) begin
         ir = i % 4;
         w = {$urandom, p_op[i]};
         w[15:12] = {p_sel[i], 2'(ir)};
         go(w, 1'b0, OPC_PREFIX, 10, 16'(p_kind[i]), 15, 16'h1);
         for (k = 1; k <= ir + 1; k++) go({$urandom, OP_RET}, 1'b0, OPC_RET_INTRA, 15, 16'(k <= ir));
      end
      $display("test prefix done");
      for (i = 0; i < 24; i++) begin
         w = {$urandom, OP_COPROC};
         ok = (w[31:29] == RPT_REGULAR || w[31:29] == RPT_USER_REPEAT_VARIANT_ZERO || w[31:29] == RPT_USER_REPEAT_VARIANT_ONE);
         ok = ok && w[14:12] != PTR_RESERVED && w[26:24] != PTR_RESERVED;
         if (ok) go(w, 1'b0, OPC_COPROC, 12, {7'h0, w[30:29], w[15], w[14:12], w[26:24]});
         else go(w, 1'b0, OPC_HW_TRAP, 13, 16'h1);
      end
      i_fetch.rest(6);
      chk("pending", 16'h0, 16'(notes.size()));
      $display("test coprocessor done");
      tally_and_finish();
   end
endmodule
